//--- rtl/eccp_defines.svh
// Register offsets, field positions, reset values and timing figures of the ECCP unit
`ifndef ECCP_DEFINES_SVH
`define ECCP_DEFINES_SVH

`define ECCP_ADDR_W 8
`define ECCP_OFF_CONTROL 8'h00
`define ECCP_OFF_DUTY_BYTE 8'h04
`define ECCP_OFF_PERIOD 8'h08
`define ECCP_OFF_COMPARE 8'h0C
`define ECCP_OFF_STATUS 8'h10
`define ECCP_OFF_CAPTURE 8'h14
`define ECCP_OFF_SHADOW 8'h18

`define ECCP_CTRL_RESET 8'h00
`define ECCP_BYTE_RESET 8'h00
`define ECCP_WORD_RESET 16'h0000

`define ECCP_MODE_OFF 4'h0
`define ECCP_MODE_RSVD 4'h1
`define ECCP_MODE_CMP_TOGGLE 4'h2
`define ECCP_MODE_CAP_ANY 4'h3
`define ECCP_MODE_CAP_FALL 4'h4
`define ECCP_MODE_CAP_RISE 4'h5
`define ECCP_MODE_CAP_RISE4 4'h6
`define ECCP_MODE_CAP_RISE16 4'h7
`define ECCP_MODE_CMP_SET 4'h8
`define ECCP_MODE_CMP_CLR 4'h9
`define ECCP_MODE_CMP_IRQ 4'hA
`define ECCP_MODE_CMP_SPECIAL 4'hB

`define ECCP_OC_SINGLE 2'h0
`define ECCP_OC_FWD 2'h1
`define ECCP_OC_HALF 2'h2
`define ECCP_OC_REV 2'h3
`define ECCP_EMB_12BIT 2'h1

`define ECCP_PRESC_4 4'h3
`define ECCP_PRESC_16 4'hF
`define ECCP_FINE_LAST 2'h3

`define ECCP_RESP_OKAY 2'h0
`define ECCP_RESP_SLVERR 2'h2

`define ECCP_LOC_FIRST 2'h0
`define ECCP_LOC_SECOND 2'h1
`define ECCP_LOC_THIRD 2'h2

`endif

//--- rtl/eccp_pkg.sv
// Types of the ECCP mode decoding and output steering unit
package eccp_pkg;

    typedef enum logic [3:0] {
        ECCP_ST_OFF = 4'b0001,
        ECCP_ST_CAPTURE = 4'b0010,
        ECCP_ST_COMPARE = 4'b0100,
        ECCP_ST_PWM = 4'b1000
    } eccp_unit_state_type;

    typedef struct packed {
        eccp_unit_state_type ustate;
        logic [7:0] ctrl;
        logic [7:0] duty_byte;
        logic [7:0] period;
        logic [15:0] cmp_val;
        logic [15:0] cap_val;
        logic match_flag;
        logic [9:0] shadow;
        logic [9:0] tb;
        logic pwm_raw;
        logic cmp_pin;
        logic cmp_eq_d;
        logic cap_d;
        logic [3:0] presc;
        logic [3:0] prev_mode;
        logic out_a;
        logic out_b;
        logic out_c;
        logic out_d;
        logic a_en;
        logic b_en;
        logic c_en;
        logic d_en;
        logic bc_alt;
        logic [1:0] a_loc;
        logic d_takeover;
        logic tmr_reset;
        logic adc_start;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } eccp_state_type;

endpackage

//--- rtl/eccp_unit.sv
// ECCP unit: mode decode, compare/capture/PWM core and output pin steering behind AXI4-Lite
`timescale 1ns/1ps
`include "eccp_defines.svh"

// Behaviour
// - Mode 0000 switches the unit off and resets it; 0001 is reserved.
// - Mode 0010 toggles output A on every compare match.
// - Capture modes pick any, falling, rising, every 4th or 16th rising edge.
// - Mode 1000 starts output A low, drives it high on match, sets flag.
// - Mode 1001 starts output A high, drives it low on match, sets flag.
// - Mode 1010 only raises the match flag; output A returns to port.
// - Mode 1011 resets the compare timer, sets flag; unit two also starts conversion.
// - On unit three the special-event code behaves as interrupt-only compare.
// - Modes 11xx are PWM; bit1 inverts A and C, bit0 inverts B and D.
// - Outside PWM the output configuration is ignored; only A serves the unit.
// - PWM configuration 00 modulates A only; B, C, D stay port pins.
// - Configuration 01 modulates D, holds A active, B and C inactive.
// - Configuration 10 modulates A and B complementary; C, D stay port pins.
// - Configuration 11 modulates B, holds C active, A and D inactive.
// - Control bits 5:4 are the duty low bits, used only in PWM.
// - Active extended bus on default routing takes B and C of units one, three.
// - A 12-bit bus width leaves B and C of units one and three usable.
// - Clearing the bridge pin select moves B and C of units one and three to the alternate port.
// - Unit two output A sits at first location, second when select cleared.
// - On 80-pin parts in extended mode the cleared select uses third location.
// - Quad PWM on units one, three takes over a standard unit's pin.
// - New duty reaches the shadow only at the end of the PWM period.
// - Duty above the period never clears the modulated output.
module eccp_unit #(
    parameter int UNIT_INDEX = 1,
    parameter bit PIN_COUNT_80 = 1'b1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [`ECCP_ADDR_W-1:0] s_axi_awaddr_in,
    input wire logic [2:0] s_axi_awprot_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    output logic [1:0] s_axi_bresp_out,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    input wire logic [`ECCP_ADDR_W-1:0] s_axi_araddr_in,
    input wire logic [2:0] s_axi_arprot_in,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    input wire logic [15:0] compare_timer_in,
    input wire logic capture_pin_in,
    input wire logic bridge_pin_select_in,
    input wire logic unit_two_pin_select_in,
    input wire logic [1:0] memory_bus_mode_in,
    input wire logic extended_mode_in,
    input wire logic memory_bus_active_in,
    output logic output_a_out,
    output logic output_b_out,
    output logic output_c_out,
    output logic output_d_out,
    output logic output_a_en_out,
    output logic output_b_en_out,
    output logic output_c_en_out,
    output logic output_d_en_out,
    output logic bc_on_alternate_port_out,
    output logic [1:0] output_a_location_out,
    output logic d_takes_standard_pin_out,
    output logic timer_reset_out,
    output logic conversion_start_out,
    output logic match_flag_out
);

    initial begin
        if (UNIT_INDEX < 1 || UNIT_INDEX > 3) begin
            $error("UNIT_INDEX must be 1, 2 or 3");
        end
    end

    eccp_pkg::eccp_state_type s;
    eccp_pkg::eccp_state_type next_s;
    eccp_pkg::eccp_unit_state_type st;
    logic [3:0] mode;
    logic [1:0] oc;
    logic cmp_eq;
    logic match_ev;
    logic rise;
    logic fall;
    logic cap_ev;
    logic wrap;
    logic bc_blocked;
    logic wr_go;
    logic rd_go;
    logic period_write;
    logic a_v;
    logic b_v;
    logic c_v;
    logic d_v;

    always_comb begin
        next_s = s;
        mode = s.ctrl[3:0];
        if (UNIT_INDEX == 3 && mode == `ECCP_MODE_CMP_SPECIAL) begin
            mode = `ECCP_MODE_CMP_IRQ;
        end
        case (mode[3:2])
            2'b11: st = eccp_pkg::ECCP_ST_PWM;
            2'b10: st = eccp_pkg::ECCP_ST_COMPARE;
            2'b01: st = eccp_pkg::ECCP_ST_CAPTURE;
            default: begin
                if (mode == `ECCP_MODE_CMP_TOGGLE) begin
                    st = eccp_pkg::ECCP_ST_COMPARE;
                end else if (mode == `ECCP_MODE_CAP_ANY) begin
                    st = eccp_pkg::ECCP_ST_CAPTURE;
                end else begin
                    st = eccp_pkg::ECCP_ST_OFF;
                end
            end
        endcase
        next_s.ustate = st;
        next_s.prev_mode = mode;

        // Bus on default routing steals B and C unless the 12-bit width is chosen
        bc_blocked = UNIT_INDEX != 2 && extended_mode_in && memory_bus_active_in && bridge_pin_select_in
            && memory_bus_mode_in != `ECCP_EMB_12BIT;
        oc = s.ctrl[7:6];
        if (bc_blocked) begin
            oc = `ECCP_OC_SINGLE;
        end

        cmp_eq = compare_timer_in == s.cmp_val;
        match_ev = st == eccp_pkg::ECCP_ST_COMPARE && cmp_eq && !s.cmp_eq_d;
        next_s.cmp_eq_d = cmp_eq;
        rise = capture_pin_in && !s.cap_d;
        fall = !capture_pin_in && s.cap_d;
        next_s.cap_d = capture_pin_in;

        // AXI4-Lite handshakes: ready is a one-cycle pulse, one transfer at a time
        wr_go = s.awready && s_axi_awvalid_in && s_axi_wvalid_in;
        rd_go = s.arready && s_axi_arvalid_in;
        next_s.awready = s_axi_awvalid_in && s_axi_wvalid_in && !s.awready && !s.bvalid;
        next_s.wready = next_s.awready;
        next_s.arready = s_axi_arvalid_in && !s.arready && !s.rvalid;
        if (s.bvalid && s_axi_bready_in) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && s_axi_rready_in) begin
            next_s.rvalid = 1'b0;
        end
        period_write = 1'b0;
        if (wr_go) begin
            next_s.bvalid = 1'b1;
            next_s.bresp = `ECCP_RESP_OKAY;
            case (s_axi_awaddr_in)
                `ECCP_OFF_CONTROL: begin
                    if (s_axi_wstrb_in[0]) begin
                        next_s.ctrl = s_axi_wdata_in[7:0];
                    end
                end
                `ECCP_OFF_DUTY_BYTE: begin
                    if (s_axi_wstrb_in[0]) begin
                        next_s.duty_byte = s_axi_wdata_in[7:0];
                    end
                end
                `ECCP_OFF_PERIOD: begin
                    if (s_axi_wstrb_in[0]) begin
                        next_s.period = s_axi_wdata_in[7:0];
                        period_write = 1'b1;
                    end
                end
                `ECCP_OFF_COMPARE: begin
                    if (s_axi_wstrb_in[0]) begin
                        next_s.cmp_val[7:0] = s_axi_wdata_in[7:0];
                    end
                    if (s_axi_wstrb_in[1]) begin
                        next_s.cmp_val[15:8] = s_axi_wdata_in[15:8];
                    end
                end
                `ECCP_OFF_STATUS: begin
                    if (s_axi_wstrb_in[0] && s_axi_wdata_in[0]) begin
                        next_s.match_flag = 1'b0;
                    end
                end
                `ECCP_OFF_CAPTURE, `ECCP_OFF_SHADOW: begin
                    next_s.bresp = `ECCP_RESP_OKAY;
                end
                default: next_s.bresp = `ECCP_RESP_SLVERR;
            endcase
        end
        if (rd_go) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = `ECCP_RESP_OKAY;
            next_s.rdata = 32'h0000_0000;
            case (s_axi_araddr_in)
                `ECCP_OFF_CONTROL: next_s.rdata[7:0] = s.ctrl;
                `ECCP_OFF_DUTY_BYTE: next_s.rdata[7:0] = s.duty_byte;
                `ECCP_OFF_PERIOD: next_s.rdata[7:0] = s.period;
                `ECCP_OFF_COMPARE: next_s.rdata[15:0] = s.cmp_val;
                `ECCP_OFF_STATUS: next_s.rdata[0] = s.match_flag;
                `ECCP_OFF_CAPTURE: next_s.rdata[15:0] = s.cap_val;
                `ECCP_OFF_SHADOW: next_s.rdata[9:0] = s.shadow;
                default: next_s.rresp = `ECCP_RESP_SLVERR;
            endcase
        end

        // Capture trigger
        cap_ev = 1'b0;
        if (mode != s.prev_mode) begin
            next_s.presc = 4'h0;
        end else if (st == eccp_pkg::ECCP_ST_CAPTURE) begin
            case (mode)
                `ECCP_MODE_CAP_ANY: cap_ev = rise || fall;
                `ECCP_MODE_CAP_FALL: cap_ev = fall;
                `ECCP_MODE_CAP_RISE: cap_ev = rise;
                `ECCP_MODE_CAP_RISE4, `ECCP_MODE_CAP_RISE16: begin
                    if (rise) begin
                        if (s.presc == (mode == `ECCP_MODE_CAP_RISE4 ? `ECCP_PRESC_4 : `ECCP_PRESC_16)) begin
                            cap_ev = 1'b1;
                            next_s.presc = 4'h0;
                        end else begin
                            next_s.presc = s.presc + 4'h1;
                        end
                    end
                end
                default: cap_ev = 1'b0;
            endcase
        end
        if (cap_ev) begin
            next_s.cap_val = compare_timer_in;
        end

        // Compare actions
        next_s.tmr_reset = 1'b0;
        next_s.adc_start = 1'b0;
        if (mode != s.prev_mode) begin
            next_s.cmp_pin = mode == `ECCP_MODE_CMP_CLR;
        end else if (match_ev) begin
            case (mode)
                `ECCP_MODE_CMP_TOGGLE: next_s.cmp_pin = !s.cmp_pin;
                `ECCP_MODE_CMP_SET: next_s.cmp_pin = 1'b1;
                `ECCP_MODE_CMP_CLR: next_s.cmp_pin = 1'b0;
                `ECCP_MODE_CMP_SPECIAL: begin
                    next_s.tmr_reset = 1'b1;
                    next_s.adc_start = UNIT_INDEX == 2;
                end
                default: next_s.cmp_pin = s.cmp_pin;
            endcase
        end
        // Set wins over a same-cycle software clear
        if (cap_ev || (match_ev && mode != `ECCP_MODE_CMP_TOGGLE)) begin
            next_s.match_flag = 1'b1;
        end

        // PWM timebase: 8-bit period plus 2 fine bits gives 10-bit duty resolution
        // Also catches a count left above a period shortened mid-count
        wrap = s.tb >= {s.period, `ECCP_FINE_LAST};
        if (st == eccp_pkg::ECCP_ST_PWM) begin
            if (wrap) begin
                next_s.tb = 10'h000;
                next_s.shadow = {s.duty_byte, s.ctrl[5:4]};
            end else begin
                next_s.tb = s.tb + 10'h001;
            end
            // Duty above the period keeps the output set all period
            next_s.pwm_raw = next_s.tb < next_s.shadow;
        end else begin
            next_s.tb = 10'h000;
            next_s.pwm_raw = 1'b0;
        end

        // Output steering
        a_v = 1'b0;
        b_v = 1'b0;
        c_v = 1'b0;
        d_v = 1'b0;
        next_s.a_en = 1'b0;
        next_s.b_en = 1'b0;
        next_s.c_en = 1'b0;
        next_s.d_en = 1'b0;
        next_s.d_takeover = 1'b0;
        case (st)
            eccp_pkg::ECCP_ST_PWM: begin
                case (oc)
                    `ECCP_OC_FWD: begin
                        a_v = 1'b1;
                        d_v = s.pwm_raw || next_s.pwm_raw ? next_s.pwm_raw : 1'b0;
                        {next_s.a_en, next_s.b_en, next_s.c_en, next_s.d_en} = 4'hF;
                        next_s.d_takeover = UNIT_INDEX != 2;
                    end
                    `ECCP_OC_HALF: begin
                        a_v = next_s.pwm_raw;
                        b_v = !next_s.pwm_raw;
                        {next_s.a_en, next_s.b_en} = 2'h3;
                    end
                    `ECCP_OC_REV: begin
                        b_v = next_s.pwm_raw;
                        c_v = 1'b1;
                        {next_s.a_en, next_s.b_en, next_s.c_en, next_s.d_en} = 4'hF;
                        next_s.d_takeover = UNIT_INDEX != 2;
                    end
                    default: begin
                        a_v = next_s.pwm_raw;
                        next_s.a_en = 1'b1;
                    end
                endcase
                // Polarity applies to driven and held-inactive levels alike
                next_s.out_a = a_v ^ mode[1];
                next_s.out_c = c_v ^ mode[1];
                next_s.out_b = b_v ^ mode[0];
                next_s.out_d = d_v ^ mode[0];
            end
            eccp_pkg::ECCP_ST_COMPARE: begin
                next_s.a_en = mode != `ECCP_MODE_CMP_IRQ;
                next_s.out_a = next_s.cmp_pin;
                next_s.out_b = 1'b0;
                next_s.out_c = 1'b0;
                next_s.out_d = 1'b0;
            end
            default: begin
                next_s.out_a = 1'b0;
                next_s.out_b = 1'b0;
                next_s.out_c = 1'b0;
                next_s.out_d = 1'b0;
            end
        endcase
        if (st == eccp_pkg::ECCP_ST_OFF) begin
            next_s.cmp_pin = 1'b0;
            next_s.shadow = 10'h000;
            next_s.presc = 4'h0;
        end

        // Pin routing
        next_s.bc_alt = UNIT_INDEX != 2 && !bridge_pin_select_in;
        if (UNIT_INDEX != 2 || unit_two_pin_select_in) begin
            next_s.a_loc = `ECCP_LOC_FIRST;
        end else if (PIN_COUNT_80 && extended_mode_in) begin
            next_s.a_loc = `ECCP_LOC_THIRD;
        end else begin
            next_s.a_loc = `ECCP_LOC_SECOND;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '0;
            s.ustate <= eccp_pkg::ECCP_ST_OFF;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready_out = s.awready;
    assign s_axi_wready_out = s.wready;
    assign s_axi_bvalid_out = s.bvalid;
    assign s_axi_bresp_out = s.bresp;
    assign s_axi_arready_out = s.arready;
    assign s_axi_rvalid_out = s.rvalid;
    assign s_axi_rdata_out = s.rdata;
    assign s_axi_rresp_out = s.rresp;
    assign output_a_out = s.out_a;
    assign output_b_out = s.out_b;
    assign output_c_out = s.out_c;
    assign output_d_out = s.out_d;
    assign output_a_en_out = s.a_en;
    assign output_b_en_out = s.b_en;
    assign output_c_en_out = s.c_en;
    assign output_d_en_out = s.d_en;
    assign bc_on_alternate_port_out = s.bc_alt;
    assign output_a_location_out = s.a_loc;
    assign d_takes_standard_pin_out = s.d_takeover;
    assign timer_reset_out = s.tmr_reset;
    assign conversion_start_out = s.adc_start;
    assign match_flag_out = s.match_flag;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_single_pulse;
        timer_reset_out ##1 !timer_reset_out;
    endsequence

    property p_off_release;
        s.ctrl[3:0] == `ECCP_MODE_OFF |=> !output_a_en_out && !output_b_en_out && !output_c_en_out && !output_d_en_out;
    endproperty
    a_off_release: assert property (p_off_release) else $error("Outputs not released in off mode");

    property p_toggle;
        s.ctrl[3:0] == `ECCP_MODE_CMP_TOGGLE && mode == s.prev_mode && match_ev |=> output_a_out != $past(output_a_out);
    endproperty
    a_toggle: assert property (p_toggle) else $error("Toggle compare did not toggle");

    property p_set_on_match;
        s.ctrl[3:0] == `ECCP_MODE_CMP_SET && mode == s.prev_mode && match_ev |=> output_a_out && match_flag_out;
    endproperty
    a_set_on_match: assert property (p_set_on_match) else $error("Set-on-match failed");

    property p_clr_on_match;
        s.ctrl[3:0] == `ECCP_MODE_CMP_CLR && mode == s.prev_mode && match_ev |=> !output_a_out && match_flag_out;
    endproperty
    a_clr_on_match: assert property (p_clr_on_match) else $error("Clear-on-match failed");

    property p_irq_only;
        mode == `ECCP_MODE_CMP_IRQ |=> !output_a_en_out;
    endproperty
    a_irq_only: assert property (p_irq_only) else $error("Interrupt-only compare drove the pin");

    property p_special_event;
        UNIT_INDEX != 3 && mode == `ECCP_MODE_CMP_SPECIAL && mode == s.prev_mode && match_ev |=> s_single_pulse;
    endproperty
    a_special_event: assert property (p_special_event) else $error("Special event pulse wrong");

    property p_unit_three_no_reset;
        UNIT_INDEX == 3 |-> !timer_reset_out;
    endproperty
    a_unit_three_no_reset: assert property (p_unit_three_no_reset) else $error("Unit three reset its timer");

    property p_single_output;
        st == eccp_pkg::ECCP_ST_PWM && oc == `ECCP_OC_SINGLE |=> output_a_en_out && !output_b_en_out && !output_d_en_out;
    endproperty
    a_single_output: assert property (p_single_output) else $error("Single output steering wrong");

    property p_shadow_at_wrap;
        s.shadow != $past(s.shadow) && s.ustate == eccp_pkg::ECCP_ST_PWM && $past(st) == eccp_pkg::ECCP_ST_PWM
            |-> $past(wrap);
    endproperty
    a_shadow_at_wrap: assert property (p_shadow_at_wrap) else $error("Shadow duty loaded mid-period");

    property p_over_period;
        st == eccp_pkg::ECCP_ST_PWM && !wrap && !period_write && s.shadow > {s.period, `ECCP_FINE_LAST}
            |=> s.pwm_raw;
    endproperty
    a_over_period: assert property (p_over_period) else $error("Output cleared with duty above period");

    property p_bus_blocks_bc;
        bc_blocked |=> !output_b_en_out && !output_c_en_out;
    endproperty
    a_bus_blocks_bc: assert property (p_bus_blocks_bc) else $error("Bus-owned B or C driven");

endmodule // eccp_unit

//--- dv/eccp_bridge_model.sv
// Bridge driver stand-in that turns owned output pins into gate levels
`timescale 1ns/1ps
module eccp_bridge_model (
    input wire logic [3:0] level_in,
    input wire logic [3:0] drive_en_in,
    output logic [3:0] gate_out
);
    // Gates pulled down: a released pin reads 0, never its last level
    assign gate_out = level_in & drive_en_in;
endmodule // eccp_bridge_model

//--- dv/enhanced_ccp_mode_and_output_steering_tb.sv
// Self-checking bench of the ECCP mode decode and output steering unit
`timescale 1ns/1ps
module enhanced_ccp_mode_and_output_steering_tb;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, cap = 1'b0, bsel = 1'b1, usel = 1'b1;
    logic ext = 1'b0, bact = 1'b0;
    logic awr, wr, bv, arr, rv, oa, ob, oc, od, ea, eb, ec, ed, alt, trst, conv, mf, dto;
    logic [1:0] bresp, rresp, loc, wresp, emb = 2'h0;
    logic [2:0] prot = 3'h0;
    logic [7:0] awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000, rd;
    logic [15:0] tmr = 16'h0000;
    logic [3:0] pins;
    integer seed = 14;
    int err_count = 0, n_tests = 0, tr_cnt = 0, t0;
    localparam logic [3:0] CMP_MODES [5] = '{4'h2, 4'h8, 4'h9, 4'hA, 4'hB};

    eccp_unit eccp_unit_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_awaddr_in(awa), .s_axi_awprot_in(prot), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_bvalid_out(bv),
        .s_axi_bready_in(br), .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
        .s_axi_araddr_in(ara), .s_axi_arprot_in(prot), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
        .s_axi_rdata_out(rd), .s_axi_rresp_out(rresp), .compare_timer_in(tmr), .capture_pin_in(cap),
        .bridge_pin_select_in(bsel), .unit_two_pin_select_in(usel), .memory_bus_mode_in(emb),
        .extended_mode_in(ext), .memory_bus_active_in(bact), .output_a_out(oa), .output_b_out(ob),
        .output_c_out(oc), .output_d_out(od), .output_a_en_out(ea), .output_b_en_out(eb),
        .output_c_en_out(ec), .output_d_en_out(ed), .bc_on_alternate_port_out(alt),
        .output_a_location_out(loc), .d_takes_standard_pin_out(dto), .timer_reset_out(trst),
        .conversion_start_out(conv), .match_flag_out(mf));
    eccp_bridge_model eccp_bridge_model_inst (.level_in({oa, ob, oc, od}), .drive_en_in({ea, eb, ec, ed}),
        .gate_out(pins));

    initial forever #10 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cap <= ~cap;
        // Unit one never starts a conversion: a stray one adds 2
        tr_cnt <= tr_cnt + int'(trst === 1'b1) + 2 * int'(conv === 1'b1);
    end

    function automatic logic [2:0] cmp_exp(input logic [3:0] m);
        case (m)
            4'h2: return 3'h6;
            4'h8: return 3'h7;
            4'h9: return 3'h5;
            default: return 3'h1;
        endcase
    endfunction
    function automatic logic [7:0] pwm_exp(input logic [1:0] o, input logic [1:0] p);
        case (o)
            2'h0: return {4'h8, ~p[1], 3'h0};
            2'h1: return {4'hF, ~p[1], p[0], p[1], ~p[0]};
            2'h2: return {4'hC, ~p[1], p[0], 2'h0};
            default: return {4'hF, p[1], ~p[0], ~p[1], p[0]};
        endcase
    endfunction
    task automatic give_verdict;
        $display("tests=%0d errors=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic hang(input int n);
        if (n >= 64) begin
            err_count++;
            give_verdict();
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awa <= a;
        wd <= d;
        prot <= 3'($random(seed));
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
            if (awr === 1'b1) awv <= 1'b0;
            if (wr === 1'b1) wv <= 1'b0;
        end while (((awv === 1'b1 && awr !== 1'b1) || (wv === 1'b1 && wr !== 1'b1)) && n < 64);
        while (bv !== 1'b1 && n < 64) begin
            @(posedge clk_in);
            n++;
        end
        wresp = bresp;
        br <= 1'b0;
        hang(n);
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (arr !== 1'b1 && n < 64);
        arv <= 1'b0;
        while (rv !== 1'b1 && n < 64) begin
            @(posedge clk_in);
            n++;
        end
        d = rd;
        r = rresp;
        rr <= 1'b0;
        hang(n);
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [3:0] m;
        logic [1:0] pol;
        logic [1:0] dl;
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        rd_reg(8'h00, d, r);
        chk(d, 32'h0000_0000);
        chk({ea, eb, ec, ed}, 4'h0);
        rd_reg(8'h1C, d, r);
        chk(r, 2'h2);
        wr_reg(8'h1C, 32'h0000_00FF);
        chk(wresp, 2'h2);
        wr_reg(8'h0C, 32'h0000_8ABC);
        chk(wresp, 2'h0);
        for (int i = 0; i < 5; i++) begin
            m = CMP_MODES[i];
            tmr <= {1'b0, 15'($random(seed))};
            wr_reg(8'h00, {24'h0000_00, 2'($random(seed)), 2'h0, m});
            t0 = tr_cnt;
            repeat (3) @(posedge clk_in);
            tmr <= 16'h8ABC;
            repeat (3) @(posedge clk_in);
            chk({{ea, oa & ea} & {2{m != 4'hB}}, mf}, cmp_exp(m));
            chk({eb, ec, ed}, 3'h0);
            chk(tr_cnt - t0, m == 4'hB);
            wr_reg(8'h00, 32'h0000_0000);
            wr_reg(8'h10, 32'h0000_0001);
            repeat (3) @(posedge clk_in);
            chk({ea, eb, ec, ed, pins}, 8'h00);
        end
        // Every capture trigger must latch the timer and raise the flag
        for (int i = 3; i < 8; i++) begin
            tmr <= 16'($random(seed));
            wr_reg(8'h00, 32'(i));
            repeat (40) @(posedge clk_in);
            rd_reg(8'h14, d, r);
            chk(d, {16'h0000, tmr});
            chk(mf, 1'b1);
            wr_reg(8'h00, 32'h0000_0000);
            wr_reg(8'h10, 32'h0000_0001);
        end
        wr_reg(8'h08, 32'h0000_0003);
        wr_reg(8'h04, 32'h0000_00FF);
        for (int o = 0; o < 4; o++) begin
            pol = 2'($random(seed));
            dl = 2'($random(seed));
            // Bus active; default routing on the last pass lets it take B and C
            bsel <= o != 2;
            emb <= o == 1 ? 2'h1 : 2'h0;
            ext <= 1'b1;
            bact <= 1'b1;
            usel <= 1'($random(seed));
            wr_reg(8'h00, {24'h0000_00, 2'(o), dl, 2'h3, pol});
            // Duty far above period: no level may move across several periods
            for (int k = 0; k < 3; k++) begin
                repeat (37) @(posedge clk_in);
                chk({ea, eb, ec, ed, pins}, pwm_exp(o == 3 ? 2'h0 : 2'(o), pol));
            end
            chk({alt, loc, dto}, {~bsel, 2'h0, o == 1});
            rd_reg(8'h18, d, r);
            chk(d, {22'h0000_00, 8'hFF, dl});
        end
        // Reset in mid-run while the bridge is driven
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        chk({ea, eb, ec, ed, pins}, 8'h00);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        rd_reg(8'h00, d, r);
        chk(d, 32'h0000_0000);
        wr_reg(8'h00, 32'h0000_0000);
        repeat (3) @(posedge clk_in);
        chk({ea, eb, ec, ed, pins}, 8'h00);
        give_verdict();
    end
endmodule // enhanced_ccp_mode_and_output_steering_tb
